// ---- hdl/hbp_dev.sv ----
// What this block does
// - Serial strap high selects four-wire serial slave
// - Clock polarity and phase come from straps
// - Bit-order strap orders address and data bits
// - Read flag first, burst flag last, always
// - Width strap picks 8 or 16 bit bus
// - Eight-bit mode decodes A0, uses low lane
// - Eight-bit mode never drives upper data lines
// - Sixteen-bit mode ignores A0, uses all lines
// - Reset pin or reset bit restores defaults
// - Global reset also resets port registers
// - Device held in reset while bit set
// - Defaults: C-bit DS3 framing, line unit off
// - Data-path resets and power-down default to one
// - Loop timing, else source bit picks clock
// - Line mode code 011: line unit, rx jitter
// - All-ones alarm fields disable payload/line alarm
// - Line enable bit enables transmitter without unit
// - Read-only register returns fixed identity code
// - Burst increments address, no new control bytes
// - Chip select release ends burst, control next
// - Byte-swap strap swaps lanes in 16-bit mode
// - Strobe-mode strap picks read/write or data strobe
`timescale 1ns/1ns
module hbp_dev #(
	parameter logic [15:0] ID_CODE = 16'h5a31 // arbitrary value
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Host port
	hbp_if.dev bus,
	// Configuration outputs
	output hbp_pkg::hbp_txclk_t tx_clk_src_o,
	output logic liu_en_o,
	output logic ja_rx_o,
	output logic payload_alarm_insert_field_off_o,
	output logic line_alarm_insert_field_off_o,
	output logic tx_en_o,
	output logic dp_rst_o,
	output logic pd_o,
	output logic in_rst_o,
	output logic [2:0] fm_o,
	output logic [2:0] lm_o,
	output logic [3:0] clock_rate_adapter_cfg_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic serial, width, swap, mode, cpol, cpha, lsbf, rst_n;
		logic sclk, mosi, cs_n, rd_n, wr_n, ds_n, rw;
		logic [9:0] a;
		logic [15:0] d;
	} hbp_pin_t;
	typedef enum logic [1:0] {S_IDLE, S_CTRL, S_DATA} hbp_sst_t;
	typedef struct packed {
		hbp_pin_t s1, s2;
		logic sclk_q, acc_q;
		logic [15:0] gcr1, gcr2;
		logic [3:0][15:0] pcr;
		hbp_sst_t sst;
		logic [15:0] csr;
		logic [4:0] cnt;
		logic srd, burst;
		logic [9:0] sadr;
		logic [7:0] osr;
		logic miso, miso_oe;
		logic [15:0] dout;
		logic [1:0] doe;
		hbp_pkg::hbp_txclk_t txc;
		logic line_interface_unit, ja, payload_alarm_insert_field, line_alarm_insert_field, txen, dpr, pd, inr;
		logic [2:0] fm, lm;
	} hbp_dst_t;
	hbp_dst_t st, nx;

	function automatic logic [15:0] rd_reg(input logic [9:0] adr,
		input hbp_dst_t s);
		if (adr == hbp_pkg::OFF_GID) return ID_CODE;
		else if (adr == hbp_pkg::OFF_GCR1) return s.gcr1;
		else if (adr == hbp_pkg::OFF_GCR2) return s.gcr2;
		else if (adr == hbp_pkg::OFF_PCR1) return s.pcr[0];
		else if (adr == hbp_pkg::OFF_PCR2) return s.pcr[1];
		else if (adr == hbp_pkg::OFF_PCR3) return s.pcr[2];
		else if (adr == hbp_pkg::OFF_PCR4) return s.pcr[3];
		else return 16'h0000;
	endfunction : rd_reg

	function automatic logic [15:0] merge(input logic [15:0] o,
		input logic [15:0] w, input logic [1:0] be);
		return {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
	endfunction : merge

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) r[i] = v[7 - i];
		return r;
	endfunction : rev8

	function automatic logic [13:0] rev14(input logic [13:0] v);
		logic [13:0] r;
		r = 14'h0000;
		for (int i = 0; i < hbp_pkg::MID_BITS; i++) r[i] = v[13 - i];
		return r;
	endfunction : rev14

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		hbp_pin_t p;
		logic acc, isrd, start, we, rise, fall, samp, laun;
		logic [9:0] wa, adr, mid;
		logic [13:0] m14;
		logic [15:0] wd, w, din;
		logic [1:0] wbe;
		logic [7:0] b;
		nx = st;
		p = st.s2;
		we = 1'b0;
		wa = 10'h000;
		wd = 16'h0000;
		wbe = 2'b00;
		b = 8'h00;
		mid = 10'h000;
		m14 = 14'h0000;
		nx.s1 = '{bus.serial_sel, bus.width, bus.byte_swap_strap,
			bus.strobe_mode, bus.serial_clock_polarity_strap,
			bus.serial_clock_phase_strap, bus.lsb_first, bus.rst_n,
			bus.sclk, bus.mosi, bus.cs_n, bus.rd_n, bus.wr_n, bus.ds_n,
			bus.rw, bus.a, bus.d};
		nx.s2 = st.s1;
		// Parallel access
		acc = p.mode ? ~p.ds_n : (~p.rd_n | ~p.wr_n);
		isrd = p.mode ? p.rw : ~p.rd_n;
		start = acc & ~st.acc_q & ~p.serial & p.rst_n;
		nx.acc_q = acc;
		if (p.width) begin
			adr = {p.a[9:1], 1'b0};
		end else begin
			adr = p.a;
		end
		w = rd_reg({adr[9:1], 1'b0}, st);
		din = p.swap ? {p.d[7:0], p.d[15:8]} : p.d;
		if (!acc) begin
			nx.doe = 2'b00;
		end
		if (start && isrd) begin
			if (p.width) begin
				nx.dout = p.swap ? {w[7:0], w[15:8]} : w;
				nx.doe = 2'b11;
			end else begin
				nx.dout = {8'h00, adr[0] ? w[15:8] : w[7:0]};
				nx.doe = 2'b01;
			end
		end else if (start) begin
			we = 1'b1;
			wa = {adr[9:1], 1'b0};
			wd = p.width ? din : {p.d[7:0], p.d[7:0]};
			wbe = p.width ? 2'b11 : (adr[0] ? 2'b10 : 2'b01);
		end
		// Serial access
		rise = p.sclk & ~st.sclk_q;
		fall = ~p.sclk & st.sclk_q;
		samp = p.cpha ? (p.cpol ? rise : fall) : (p.cpol ? fall : rise);
		laun = p.cpha ? (p.cpol ? fall : rise) : (p.cpol ? rise : fall);
		nx.sclk_q = p.sclk;
		if (!p.serial || p.cs_n || !p.rst_n) begin
			nx.sst = S_IDLE;
			nx.cnt = 5'h00;
			nx.miso_oe = 1'b0;
		end else begin
			if (st.sst == S_IDLE) nx.sst = S_CTRL;
			if (samp) begin
				nx.csr = {st.csr[14:0], p.mosi};
				nx.cnt = st.cnt + 5'h01;
			end
			if (samp && st.sst != S_DATA && st.cnt == hbp_pkg::CTRL_LAST) begin
				m14 = p.lsbf ? rev14(nx.csr[14:1]) : nx.csr[14:1];
				// Address sits above the pad bits
				mid = m14[13 -: hbp_pkg::AW];
				nx.srd = nx.csr[15];
				nx.burst = nx.csr[0];
				nx.sadr = mid;
				nx.cnt = 5'h00;
				nx.sst = S_DATA;
				w = rd_reg({mid[9:1], 1'b0}, st);
				b = mid[0] ? w[15:8] : w[7:0];
				nx.osr = p.lsbf ? rev8(b) : b;
				nx.miso_oe = nx.csr[15];
			end else if (samp && st.sst == S_DATA
				&& st.cnt == hbp_pkg::BYTE_LAST) begin
				b = p.lsbf ? rev8(nx.csr[7:0]) : nx.csr[7:0];
				nx.cnt = 5'h00;
				if (!st.srd) begin
					we = 1'b1;
					wa = {st.sadr[9:1], 1'b0};
					wd = {b, b};
					wbe = st.sadr[0] ? 2'b10 : 2'b01;
				end
				if (st.burst) begin
					nx.sadr = st.sadr + 10'h001;
					w = rd_reg({nx.sadr[9:1], 1'b0}, st);
					b = nx.sadr[0] ? w[15:8] : w[7:0];
					nx.osr = p.lsbf ? rev8(b) : b;
				end else begin
					nx.sst = S_CTRL;
					nx.miso_oe = 1'b0;
				end
			end else if (laun && st.sst == S_DATA && st.cnt != 5'h00) begin
				nx.osr = {st.osr[6:0], 1'b0};
			end
		end
		nx.miso = nx.osr[7];
		// Register writes
		if (we) begin
			if (wa == hbp_pkg::OFF_GCR1) nx.gcr1 = merge(st.gcr1, wd, wbe);
			else if (wa == hbp_pkg::OFF_GCR2) nx.gcr2 = merge(st.gcr2, wd, wbe);
			else if (wa == hbp_pkg::OFF_PCR1) nx.pcr[0] = merge(st.pcr[0], wd, wbe);
			else if (wa == hbp_pkg::OFF_PCR2) nx.pcr[1] = merge(st.pcr[1], wd, wbe);
			else if (wa == hbp_pkg::OFF_PCR3) nx.pcr[2] = merge(st.pcr[2], wd, wbe);
			else if (wa == hbp_pkg::OFF_PCR4) nx.pcr[3] = merge(st.pcr[3], wd, wbe);
		end
		// Global reset hold
		if (!p.rst_n || nx.gcr1[hbp_pkg::GCR1_RST_B]) begin
			nx.gcr1 = p.rst_n ? hbp_pkg::GCR1_HOLD : hbp_pkg::GCR1_RST;
			nx.gcr2 = hbp_pkg::GCR2_RST;
			nx.pcr = {hbp_pkg::PCR4_RST, hbp_pkg::PCR3_RST,
				hbp_pkg::PCR2_RST, hbp_pkg::PCR1_RST};
		end
		// Derived controls
		nx.inr = ~p.rst_n | nx.gcr1[hbp_pkg::GCR1_RST_B];
		nx.fm = nx.pcr[1][hbp_pkg::PCR2_FM_LO +: 3];
		nx.lm = nx.pcr[1][hbp_pkg::PCR2_LM_LO +: 3];
		nx.line_interface_unit = nx.lm != hbp_pkg::LM_LIU_OFF;
		nx.ja = nx.lm == hbp_pkg::LM_LIU_JA_RX;
		nx.payload_alarm_insert_field = nx.pcr[0][hbp_pkg::PCR1_PAYLOAD_ALARM_INSERT_FIELD_LO +: 3] == hbp_pkg::PAYLOAD_ALARM_INSERT_FIELD_OFF;
		nx.line_alarm_insert_field = nx.pcr[0][hbp_pkg::PCR1_LINE_ALARM_INSERT_FIELD_LO +: 2] == hbp_pkg::LINE_ALARM_INSERT_FIELD_OFF;
		nx.dpr = nx.inr | nx.gcr1[hbp_pkg::GCR1_DP_B]
			| nx.pcr[0][hbp_pkg::PCR1_DP_B];
		nx.pd = nx.pcr[0][hbp_pkg::PCR1_PD_B];
		nx.txen = (nx.line_interface_unit | nx.pcr[1][hbp_pkg::PCR2_TRANSMIT_LINE_ENABLE_BIT_B])
			& ~nx.dpr & ~nx.pd;
		if (nx.pcr[2][hbp_pkg::PCR3_LOOP_TIMING_BIT_B]) nx.txc = hbp_pkg::TXC_RX;
		else if (nx.pcr[2][hbp_pkg::PCR3_TRANSMIT_CLOCK_SOURCE_BIT_B]) nx.txc = hbp_pkg::TXC_EXT;
		else nx.txc = hbp_pkg::TXC_CLOCK_RATE_ADAPTER;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st <= '0;
			st.gcr1 <= hbp_pkg::GCR1_RST;
			st.pcr[0] <= hbp_pkg::PCR1_RST;
			st.dpr <= 1'b1;
			st.pd <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign bus.d_d = st.dout;
	assign bus.d_d_oe = st.doe;
	assign bus.miso_d = st.miso;
	assign bus.miso_oe = st.miso_oe;
	assign tx_clk_src_o = st.txc;
	assign liu_en_o = st.line_interface_unit;
	assign ja_rx_o = st.ja;
	assign payload_alarm_insert_field_off_o = st.payload_alarm_insert_field;
	assign line_alarm_insert_field_off_o = st.line_alarm_insert_field;
	assign tx_en_o = st.txen;
	assign dp_rst_o = st.dpr;
	assign pd_o = st.pd;
	assign in_rst_o = st.inr;
	assign fm_o = st.fm;
	assign lm_o = st.lm;
	assign clock_rate_adapter_cfg_o = st.gcr2[hbp_pkg::GCR2_CLOCK_RATE_ADAPTER_LO +: 4];
endmodule : hbp_dev

// ---- hdl/hbp_pkg.sv ----
package hbp_pkg;
	// ------------------------------------------------------------
	// Widths and device register map
	// ------------------------------------------------------------
	localparam int AW = 10;
	localparam int DW = 16;
	localparam logic [9:0] OFF_GID = 10'h000;
	localparam logic [9:0] OFF_GCR1 = 10'h002;
	localparam logic [9:0] OFF_GCR2 = 10'h004;
	localparam logic [9:0] OFF_PCR1 = 10'h040;
	localparam logic [9:0] OFF_PCR2 = 10'h042;
	localparam logic [9:0] OFF_PCR3 = 10'h044;
	localparam logic [9:0] OFF_PCR4 = 10'h046;
	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int GCR1_RST_B = 0;
	localparam int GCR1_DP_B = 1;
	localparam int GCR2_CLOCK_RATE_ADAPTER_LO = 0;
	localparam int PCR1_DP_B = 0;
	localparam int PCR1_PD_B = 1;
	localparam int PCR1_PAYLOAD_ALARM_INSERT_FIELD_LO = 2;
	localparam int PCR1_LINE_ALARM_INSERT_FIELD_LO = 5;
	localparam int PCR2_FM_LO = 0;
	localparam int PCR2_LM_LO = 8;
	localparam int PCR2_TRANSMIT_LINE_ENABLE_BIT_B = 11;
	localparam int PCR3_LOOP_TIMING_BIT_B = 0;
	localparam int PCR3_TRANSMIT_CLOCK_SOURCE_BIT_B = 1;
	localparam logic [15:0] GCR1_RST = 16'h0002;
	localparam logic [15:0] GCR1_HOLD = 16'h0003;
	localparam logic [15:0] GCR2_RST = 16'h0000;
	localparam logic [15:0] PCR1_RST = 16'h0003;
	localparam logic [15:0] PCR2_RST = 16'h0000;
	localparam logic [15:0] PCR3_RST = 16'h0000;
	localparam logic [15:0] PCR4_RST = 16'h0000;
	localparam logic [2:0] FM_CBIT_DS3 = 3'h0;
	localparam logic [2:0] LM_LIU_OFF = 3'h0;
	localparam logic [2:0] LM_LIU_JA_RX = 3'h3;
	localparam logic [2:0] PAYLOAD_ALARM_INSERT_FIELD_OFF = 3'h7;
	localparam logic [1:0] LINE_ALARM_INSERT_FIELD_OFF = 2'h3;
	// ------------------------------------------------------------
	// Serial frame
	// ------------------------------------------------------------
	localparam int MID_BITS = 14;
	localparam logic [3:0] MID_PAD = 4'h0;
	localparam logic [4:0] CTRL_LAST = 5'h0f;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [5:0] CTRL_BITS = 6'h10;
	localparam logic [5:0] BYTE_BITS = 6'h08;
	// ------------------------------------------------------------
	// Host timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int HALF_NS = 800;
	localparam int STB_NS = 1000;
	localparam int GAP_NS = 800;
	localparam logic [7:0] HALF_C = 8'((HALF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] STB_C = 8'((STB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] GAP_C = 8'((GAP_NS + CLK_NS - 1) / CLK_NS);
	// ------------------------------------------------------------
	// Host command registers
	// ------------------------------------------------------------
	localparam logic [3:0] H_CFG = 4'h0;
	localparam logic [3:0] H_ADDR = 4'h1;
	localparam logic [3:0] H_WDATA = 4'h2;
	localparam logic [3:0] H_GO = 4'h3;
	localparam logic [3:0] H_STAT = 4'h4;
	localparam logic [3:0] H_RDATA = 4'h5;
	localparam int CFG_SER = 0;
	localparam int CFG_WIDTH = 1;
	localparam int CFG_SWAP = 2;
	localparam int CFG_MODE = 3;
	localparam int CFG_CPOL = 4;
	localparam int CFG_CPHA = 5;
	localparam int CFG_LSBF = 6;
	localparam int CFG_RST = 7;
	localparam int HA_RW = 15;
	localparam int HA_TWO = 14;
	typedef enum logic [1:0] {TXC_CLOCK_RATE_ADAPTER, TXC_EXT, TXC_RX} hbp_txclk_t;
endpackage : hbp_pkg

// ---- hdl/hbp_if.sv ----
`timescale 1ns/1ns
interface hbp_if;
	// Straps and reset pin, set by the host side
	logic serial_sel, width, byte_swap_strap, strobe_mode;
	logic serial_clock_polarity_strap, serial_clock_phase_strap, lsb_first;
	logic rst_n;
	// Parallel bus
	logic [9:0] a;
	logic rd_n, wr_n, ds_n, rw;
	logic [15:0] d_h, d_d, d;
	logic [1:0] d_h_oe, d_d_oe;
	// Serial bus
	logic sclk, mosi, cs_n, miso_d, miso_oe, miso;
	// Wire resolution per byte lane
	assign d[7:0] = d_d_oe[0] ? d_d[7:0] : (d_h_oe[0] ? d_h[7:0] : 8'h00);
	assign d[15:8] = d_d_oe[1] ? d_d[15:8] : (d_h_oe[1] ? d_h[15:8] : 8'h00);
	assign miso = miso_oe ? miso_d : 1'b0;
	modport dev(input serial_sel, width, byte_swap_strap, strobe_mode,
		serial_clock_polarity_strap, serial_clock_phase_strap, lsb_first,
		rst_n, a, rd_n, wr_n, ds_n, rw, d, sclk, mosi, cs_n,
		output d_d, d_d_oe, miso_d, miso_oe);
	modport host(output serial_sel, width, byte_swap_strap, strobe_mode,
		serial_clock_polarity_strap, serial_clock_phase_strap, lsb_first,
		rst_n, a, rd_n, wr_n, ds_n, rw, d_h, d_h_oe, sclk, mosi, cs_n,
		input d, miso);
endinterface : hbp_if

// ---- hdl/hbp_host.sv ----
`timescale 1ns/1ns
module hbp_host (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Command port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Device port
	hbp_if.host bus
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {H_IDLE, H_PSTB, H_SER, H_SEND, H_GAP} hbp_hst_t;
	typedef struct packed {
		logic [15:0] ds1, ds2;
		logic ms1, ms2;
		logic [7:0] cfg;
		logic [15:0] haddr, wdat, rdat, rdo;
		hbp_hst_t hs;
		logic [7:0] tmr;
		logic [6:0] k, kend;
		logic [31:0] tx;
		logic [15:0] rx;
		logic sclk, mosi, cs_n, rd_n, wr_n, ds_n, rw;
		logic [15:0] dh;
		logic [1:0] doe;
	} hbp_hs_t;
	hbp_hs_t st, nx;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) r[i] = v[7 - i];
		return r;
	endfunction : rev8

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic ser, lsbf, cpha, rwf, two;
		logic [13:0] mid;
		logic [7:0] b0, b1;
		nx = st;
		ser = st.cfg[hbp_pkg::CFG_SER];
		lsbf = st.cfg[hbp_pkg::CFG_LSBF];
		cpha = st.cfg[hbp_pkg::CFG_CPHA];
		rwf = st.haddr[hbp_pkg::HA_RW];
		two = st.haddr[hbp_pkg::HA_TWO];
		mid = {st.haddr[9:0], hbp_pkg::MID_PAD};
		b0 = lsbf ? rev8(st.wdat[7:0]) : st.wdat[7:0];
		b1 = lsbf ? rev8(st.wdat[15:8]) : st.wdat[15:8];
		if (lsbf) begin
			mid = {hbp_pkg::MID_PAD, 10'h000};
			for (int i = 0; i < hbp_pkg::AW; i++) mid[i] = st.haddr[9 - i];
		end
		nx.ds1 = bus.d;
		nx.ds2 = st.ds1;
		nx.ms1 = bus.miso;
		nx.ms2 = st.ms1;
		// Command port
		if (wr_i && addr_i == hbp_pkg::H_CFG) nx.cfg = wdata_i[7:0];
		else if (wr_i && addr_i == hbp_pkg::H_ADDR) nx.haddr = wdata_i;
		else if (wr_i && addr_i == hbp_pkg::H_WDATA) nx.wdat = wdata_i;
		if (rd_i && addr_i == hbp_pkg::H_STAT) nx.rdo = {15'h0000, st.hs != H_IDLE};
		else if (rd_i && addr_i == hbp_pkg::H_RDATA) nx.rdo = st.rdat;
		else if (rd_i) nx.rdo = {8'h00, st.cfg};
		// Transfer sequencer
		case (st.hs)
			H_IDLE: begin
				nx.sclk = st.cfg[hbp_pkg::CFG_CPOL];
				if (wr_i && addr_i == hbp_pkg::H_GO && ser) begin
					nx.cs_n = 1'b0;
					nx.k = 7'h00;
					nx.tmr = 8'h00;
					nx.kend = {(hbp_pkg::CTRL_BITS + (two ? 6'h10 : hbp_pkg::BYTE_BITS)), 1'b0};
					nx.tx = {rwf, mid, two, b0, b1};
					nx.hs = H_SER;
				end else if (wr_i && addr_i == hbp_pkg::H_GO) begin
					nx.rw = rwf;
					nx.ds_n = ~st.cfg[hbp_pkg::CFG_MODE];
					nx.rd_n = st.cfg[hbp_pkg::CFG_MODE] | ~rwf;
					nx.wr_n = st.cfg[hbp_pkg::CFG_MODE] | rwf;
					nx.dh = st.cfg[hbp_pkg::CFG_WIDTH] ? st.wdat : {8'h00, st.wdat[7:0]};
					nx.doe = rwf ? 2'b00 : (st.cfg[hbp_pkg::CFG_WIDTH] ? 2'b11 : 2'b01);
					nx.tmr = 8'h00;
					nx.hs = H_PSTB;
				end
			end
			H_PSTB: begin
				nx.tmr = st.tmr + 8'h01;
				if (st.tmr == hbp_pkg::STB_C - 8'h01) begin
					if (rwf) nx.rdat = st.cfg[hbp_pkg::CFG_WIDTH] ? st.ds2 : {8'h00, st.ds2[7:0]};
					nx.rd_n = 1'b1;
					nx.wr_n = 1'b1;
					nx.ds_n = 1'b1;
					nx.doe = 2'b00;
					nx.tmr = 8'h00;
					nx.hs = H_GAP;
				end
			end
			H_SER: begin
				nx.tmr = st.tmr + 8'h01;
				if (st.tmr == 8'h00) begin
					if (st.k == st.kend) begin
						if (!cpha) nx.sclk = ~st.sclk;
					end else if (!st.k[0]) begin
						if (cpha || st.k != 7'h00) nx.sclk = ~st.sclk;
						nx.mosi = st.tx[31];
						nx.tx = {st.tx[30:0], 1'b0};
					end else begin
						nx.sclk = ~st.sclk;
						if (st.k[6:1] >= hbp_pkg::CTRL_BITS) nx.rx = {st.rx[14:0], st.ms2};
					end
				end
				if (st.tmr == hbp_pkg::HALF_C - 8'h01) begin
					nx.tmr = 8'h00;
					nx.k = st.k + 7'h01;
					if (st.k == st.kend) nx.hs = H_SEND;
				end
			end
			H_SEND: begin
				nx.cs_n = 1'b1;
				nx.tmr = 8'h00;
				if (rwf) nx.rdat = two ? {st.rx[7:0], st.rx[15:8]} : {8'h00, st.rx[7:0]};
				if (rwf && lsbf) nx.rdat = two ? {rev8(st.rx[7:0]), rev8(st.rx[15:8])}
					: {8'h00, rev8(st.rx[7:0])};
				nx.hs = H_GAP;
			end
			default: begin
				nx.tmr = st.tmr + 8'h01;
				if (st.tmr == hbp_pkg::GAP_C - 8'h01) nx.hs = H_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st <= '0;
			st.cs_n <= 1'b1;
			st.rd_n <= 1'b1;
			st.wr_n <= 1'b1;
			st.ds_n <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata_o = st.rdo;
	assign bus.serial_sel = st.cfg[hbp_pkg::CFG_SER];
	assign bus.width = st.cfg[hbp_pkg::CFG_WIDTH];
	assign bus.byte_swap_strap = st.cfg[hbp_pkg::CFG_SWAP];
	assign bus.strobe_mode = st.cfg[hbp_pkg::CFG_MODE];
	assign bus.serial_clock_polarity_strap = st.cfg[hbp_pkg::CFG_CPOL];
	assign bus.serial_clock_phase_strap = st.cfg[hbp_pkg::CFG_CPHA];
	assign bus.lsb_first = st.cfg[hbp_pkg::CFG_LSBF];
	assign bus.rst_n = ~st.cfg[hbp_pkg::CFG_RST];
	assign bus.a = st.haddr[9:0];
	assign bus.rd_n = st.rd_n;
	assign bus.wr_n = st.wr_n;
	assign bus.ds_n = st.ds_n;
	assign bus.rw = st.rw;
	assign bus.d_h = st.dh;
	assign bus.d_h_oe = st.doe;
	assign bus.sclk = st.sclk;
	assign bus.mosi = st.mosi;
	assign bus.cs_n = st.cs_n;
endmodule : hbp_host

// ---- tb/hbp_assertions.sv ----
`timescale 1ns/1ns
module hbp_chk (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Straps and reset pin
	input wire logic serial_sel,
	input wire logic width,
	input wire logic strobe_mode,
	input wire logic rst_n,
	// Bus
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ds_n,
	input wire logic rw,
	input wire logic [1:0] d_d_oe,
	input wire logic cs_n,
	input wire logic miso_oe
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// Parallel cycles
	// ------------------------------------------------------------
	sequence s_par;
		!serial_sel && rst_n && $past(rst_n, 3);
	endsequence
	sequence s_rd;
		s_par ##0 ($fell(rd_n) && !strobe_mode);
	endsequence
	property p_rd8;
		s_rd ##0 !width |-> ##3 d_d_oe == 2'b01;
	endproperty
	a_rd8: assert property (p_rd8) else $error("8-bit lane");
	property p_rd16;
		s_rd ##0 width |-> ##3 d_d_oe == 2'b11;
	endproperty
	a_rd16: assert property (p_rd16) else $error("16-bit lanes");
	property p_up8;
		!width && $past(width, 8) == 1'b0 |-> !d_d_oe[1];
	endproperty
	a_up8: assert property (p_up8) else $error("upper lane driven");
	property p_dsr;
		s_par ##0 ($fell(ds_n) && strobe_mode && rw) |-> ##3 d_d_oe != 2'b00;
	endproperty
	a_dsr: assert property (p_dsr) else $error("strobe read");
	property p_wr;
		s_par ##0 (($fell(wr_n) && !strobe_mode) ||
			($fell(ds_n) && strobe_mode && !rw)) |-> (d_d_oe == 2'b00) [*6];
	endproperty
	a_wr: assert property (p_wr) else $error("write drove bus");
	property p_rel;
		$rose(rd_n) || $rose(ds_n) |-> ##3 d_d_oe == 2'b00;
	endproperty
	a_rel: assert property (p_rel) else $error("bus not released");
	// ------------------------------------------------------------
	// Serial mode
	// ------------------------------------------------------------
	property p_ser;
		serial_sel && $past(serial_sel, 8) |-> d_d_oe == 2'b00;
	endproperty
	a_ser: assert property (p_ser) else $error("bus in serial");
	property p_par;
		!serial_sel && $past(serial_sel, 8) == 1'b0 |-> !miso_oe;
	endproperty
	a_par: assert property (p_par) else $error("miso in parallel");
	property p_cs;
		cs_n && $past(cs_n, 4) |-> !miso_oe;
	endproperty
	a_cs: assert property (p_cs) else $error("miso while idle");
endmodule : hbp_chk

// ---- tb/host_bus_port_and_init_tb.sv ----
`timescale 1ns/1ns
module host_bus_port_and_init_tb;
	localparam logic [15:0] ID = 16'h3c96; // arbitrary value
	localparam logic [7:0] C16 = 8'h02;
	logic mclk_i, rst_i, wr_i, rd_i;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o, r;
	hbp_pkg::hbp_txclk_t txc;
	logic line_interface_unit, ja, payload_alarm_insert_field, line_alarm_insert_field, txen, dpr, pd, inr;
	logic [2:0] fm, lm;
	logic [3:0] clock_rate_adapter;
	int n_mismatch, cmp_count;
	hbp_if ifc();
	hbp_host u_hbp_host(.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.bus(ifc.host));
	hbp_dev #(.ID_CODE(ID)) u_hbp_dev(.mclk_i(mclk_i), .rst_i(rst_i),
		.bus(ifc.dev), .tx_clk_src_o(txc), .liu_en_o(line_interface_unit), .ja_rx_o(ja),
		.payload_alarm_insert_field_off_o(payload_alarm_insert_field), .line_alarm_insert_field_off_o(line_alarm_insert_field), .tx_en_o(txen),
		.dp_rst_o(dpr), .pd_o(pd), .in_rst_o(inr), .fm_o(fm), .lm_o(lm),
		.clock_rate_adapter_cfg_o(clock_rate_adapter));
	hbp_chk u_hbp_chk(.mclk_i(mclk_i), .rst_i(rst_i),
		.serial_sel(ifc.serial_sel), .width(ifc.width),
		.strobe_mode(ifc.strobe_mode), .rst_n(ifc.rst_n), .rd_n(ifc.rd_n),
		.wr_n(ifc.wr_n), .ds_n(ifc.ds_n), .rw(ifc.rw),
		.d_d_oe(ifc.d_d_oe), .cs_n(ifc.cs_n), .miso_oe(ifc.miso_oe));
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic hw(input logic [3:0] a, input logic [15:0] w);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= w;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : hw
	task automatic hr(input logic [3:0] a, output logic [15:0] q);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 q = rdata_o;
	endtask : hr
	task automatic acc(input logic [7:0] c, input logic [15:0] a,
		input logic [15:0] w, output logic [15:0] q);
		int i;
		hw(hbp_pkg::H_CFG, {8'h00, c});
		hw(hbp_pkg::H_ADDR, a);
		hw(hbp_pkg::H_WDATA, w);
		hw(hbp_pkg::H_GO, 16'h0000);
		q = 16'h0001;
		for (i = 0; i < 500 && q[0] !== 1'b0; i++)
			hr(hbp_pkg::H_STAT, q);
		chk(16'(q[0]), 16'h0000);
		hr(hbp_pkg::H_RDATA, q);
	endtask : acc
	task automatic pw(input logic [7:0] c, input logic [9:0] a,
		input logic [15:0] w);
		acc(c, {6'h00, a}, w, r);
	endtask : pw
	task automatic pr(input logic [7:0] c, input logic [9:0] a,
		input logic [15:0] e);
		acc(c, {6'h20, a}, 16'h0000, r);
		chk(r, e);
	endtask : pr
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_init();
		pr(C16, hbp_pkg::OFF_GID, ID);
		pw(C16, hbp_pkg::OFF_GID, ~ID);
		pr(C16, hbp_pkg::OFF_GID, ID);
		pr(C16, hbp_pkg::OFF_GCR1, hbp_pkg::GCR1_RST);
		pr(C16, hbp_pkg::OFF_PCR1, hbp_pkg::PCR1_RST);
		pr(C16, hbp_pkg::OFF_PCR2, hbp_pkg::PCR2_RST);
		chk(16'({dpr, pd, inr, line_interface_unit, fm}), 16'h0060);
		pw(C16, hbp_pkg::OFF_GCR1, 16'h0000);
		chk(16'({dpr, pd}), 16'h0003);
		pw(C16, hbp_pkg::OFF_PCR1, 16'h0002);
		chk(16'({dpr, pd}), 16'h0001);
	endtask : t_init
	task automatic t_grst();
		pw(C16, hbp_pkg::OFF_GCR1, 16'h0001);
		chk(16'({inr, dpr, pd}), 16'h0007);
		pr(C16, hbp_pkg::OFF_GCR1, hbp_pkg::GCR1_HOLD);
		pr(C16, hbp_pkg::OFF_PCR1, hbp_pkg::PCR1_RST);
		pw(C16, hbp_pkg::OFF_PCR2, 16'h0300);
		pr(C16, hbp_pkg::OFF_PCR2, hbp_pkg::PCR2_RST);
		pw(C16, hbp_pkg::OFF_GCR1, 16'h0000);
		chk(16'(inr), 16'h0000);
		pw(C16, hbp_pkg::OFF_PCR4, 16'h1234);
		hw(hbp_pkg::H_CFG, 16'h0082);
		repeat (8) @(posedge mclk_i);
		hw(hbp_pkg::H_CFG, 16'h0002);
		repeat (6) @(posedge mclk_i);
		pr(C16, hbp_pkg::OFF_PCR4, hbp_pkg::PCR4_RST);
		pr(C16, hbp_pkg::OFF_GCR1, hbp_pkg::GCR1_RST);
	endtask : t_grst
	task automatic t_cfg();
		pw(C16, hbp_pkg::OFF_GCR1, 16'h0000);
		pw(C16, hbp_pkg::OFF_PCR1, 16'h007c);
		chk(16'({payload_alarm_insert_field, line_alarm_insert_field, dpr, pd}), 16'h000c);
		pw(C16, hbp_pkg::OFF_PCR2, 16'h0300);
		chk(16'({line_interface_unit, ja, txen, lm}), 16'h003b);
		pw(C16, hbp_pkg::OFF_PCR2, 16'h0800);
		chk(16'({line_interface_unit, txen}), 16'h0001);
		for (int i = 0; i < 4; i++) begin
			pw(C16, hbp_pkg::OFF_PCR3, 16'(i));
			chk(16'(txc), i[0] ? 16'(hbp_pkg::TXC_RX) : (i[1] ?
				16'(hbp_pkg::TXC_EXT) : 16'(hbp_pkg::TXC_CLOCK_RATE_ADAPTER)));
		end
	endtask : t_cfg
	task automatic t_bus();
		pw(8'h00, hbp_pkg::OFF_PCR4, 16'h00a5);
		pw(8'h00, 10'h047, 16'h005a);
		pr(C16, hbp_pkg::OFF_PCR4, 16'h5aa5);
		pr(8'h00, 10'h047, 16'h005a);
		pr(C16, 10'h047, 16'h5aa5);
		pw(8'h06, hbp_pkg::OFF_PCR4, 16'h1234);
		pr(C16, hbp_pkg::OFF_PCR4, 16'h3412);
		pw(8'h0a, hbp_pkg::OFF_PCR4, 16'hc3e1);
		pr(8'h0a, hbp_pkg::OFF_PCR4, 16'hc3e1);
		pr(C16, hbp_pkg::OFF_PCR4, 16'hc3e1);
	endtask : t_bus
	task automatic t_spi();
		logic [7:0] c;
		logic [15:0] v;
		for (int i = 0; i < 8; i++) begin
			c = {1'b0, 3'(i), 4'h1};
			v = 16'h96c3 + 16'(i * 257);
			acc(c, {6'h10, hbp_pkg::OFF_PCR4}, v, r);
			acc(c, {6'h30, hbp_pkg::OFF_PCR4}, 16'h0000, r);
			chk(r, v);
			pr(C16, hbp_pkg::OFF_PCR4, v);
			acc(c, {6'h20, 10'h047}, 16'h0000, r);
			chk(16'(r[7:0]), 16'(v[15:8]));
			chk(16'({ifc.sclk, ifc.cs_n}), 16'({i[0], 1'b1}));
		end
	endtask : t_spi
	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#6000000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		rst_i = 1'b1;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		t_init();
		t_grst();
		t_cfg();
		t_bus();
		t_spi();
		report_and_stop();
	end
endmodule : host_bus_port_and_init_tb
